// >>> dfp_bus_map.vh
// Purpose: Shared constants of the DDR flash bus port and its FIFO.
// Assumes: Included by bare name from every design file of the port.
// Notes:   Word addresses count 16-bit words; latencies are in bus clocks.
`ifndef DFP_BUS_MAP_VH
`define DFP_BUS_MAP_VH

// ----------------------------------------------------------------
// Command/address word layout
// ----------------------------------------------------------------
`define DFP_CA_BYTES        3'h6
`define DFP_CA_RW_BIT       47
`define DFP_CA_SPACE_BIT    46
`define DFP_CA_BURST_BIT    45
`define DFP_CA_UPPER_MSB    44
`define DFP_CA_UPPER_LSB    16
`define DFP_CA_LOWER_MSB    2

// ----------------------------------------------------------------
// Page geometry and latency coding
// ----------------------------------------------------------------
`define DFP_PAGE_WORDS      5'h10
`define DFP_PAGE_LAST       4'hf
`define DFP_SUBPAGE_MASK    3'h7
`define DFP_LAT_BASE        5'h05
`define DFP_LAT_CODE_MAX    4'hb
`define DFP_LAT_MAX         5'h10

// ----------------------------------------------------------------
// Write FIFO shape: space bit, 32-bit address, 16-bit word
// ----------------------------------------------------------------
`define DFP_FIFO_WIDTH      49
`define DFP_FIFO_DEPTH      32
`define DFP_FIFO_AW         5

`endif

// >>> dfp_fifo.v
// Purpose: Flip-flop FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Full and empty are exact; a push and a pop may share a cycle.
`include "dfp_bus_map.vh"

module dfp_fifo #(
   parameter WIDTH = `DFP_FIFO_WIDTH,
   parameter DEPTH = `DFP_FIFO_DEPTH,
   parameter AW = `DFP_FIFO_AW
) (
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [WIDTH-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);

   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_ff;
   reg [AW-1:0] rd_ptr_ff;
   reg [AW:0] count_ff;
   wire push;
   wire pop;

   // ----------------------------------------------------------------
   // Flags and handshakes
   // ----------------------------------------------------------------
   assign o_in_ready = (count_ff != DEPTH[AW:0]);
   assign o_out_valid = (count_ff != {(AW+1){1'b0}});
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;
   assign o_out_data = mem_ff[rd_ptr_ff];

   // Storage has no reset; only the pointers and the count carry control state
   always @(posedge i_clk_sys) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= i_in_data;
      end
   end

   // Pointers wrap naturally since depth is a power of two
   always @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         case ({push, pop})
            2'b10: count_ff <= count_ff + 1'b1;
            2'b01: count_ff <= count_ff - 1'b1;
            default: count_ff <= count_ff;
         endcase
      end
   end

endmodule

// >>> dfp_flash_port.v
// Purpose: Device-side transaction engine of a DDR 8-bit flash bus port.
// Assumes: Bus clock far slower than i_clk_sys; edges found by sampling.
// Notes:   Reads fetch words from the user array; writes go to a FIFO.
`include "dfp_bus_map.vh"

module dfp_flash_port (
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_bus_clock,
   input wire i_cs_n,
   input wire [7:0] i_dq,
   output reg [7:0] o_dq,
   output reg o_dq_oe,
   output reg o_read_write_strobe,
   output reg o_read_write_strobe_oe,
   input wire [3:0] i_latency_count,
   output reg [31:0] o_rd_addr,
   input wire [15:0] i_rd_data,
   output wire o_wr_valid,
   input wire i_wr_ready,
   output wire o_wr_space,
   output wire [31:0] o_wr_addr,
   output wire [15:0] o_wr_data,
   output reg o_wr_overrun
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_CA = 3'h1;
   localparam ST_LAT = 3'h2;
   localparam ST_RD = 3'h3;
   localparam ST_WR = 3'h4;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Latency clocks from code; reserved codes fall back to the maximum
   function [4:0] lat_clocks;
      input [3:0] code;
      begin
         if (code > `DFP_LAT_CODE_MAX) begin
            lat_clocks = `DFP_LAT_MAX;
         end else begin
            lat_clocks = `DFP_LAT_BASE + {1'b0, code};
         end
      end
   endfunction

   // Extra clocks at the first page crossing of a linear read
   function [4:0] gap_calc;
      input [2:0] off;
      input [4:0] lat;
      reg [4:0] sum;
      begin
         sum = {2'b00, off} + lat;
         if (sum > `DFP_PAGE_WORDS) begin
            gap_calc = sum - `DFP_PAGE_WORDS;
         end else begin
            gap_calc = 5'h00;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg ck_m_ff;
   reg ck_s_ff;
   reg ck_d_ff;
   reg cs_m_ff;
   reg cs_s_ff;
   reg [7:0] dq_m_ff;
   reg [7:0] dq_s_ff;
   reg [2:0] state_ff;
   reg [2:0] ca_cnt_ff;
   reg [47:0] ca_ff;
   reg [4:0] lat_cnt_ff;
   reg [4:0] gap_ff;
   reg page_end_ff;
   reg [3:0] cross_at_ff;
   reg [7:0] byte_b_ff;
   reg word_ok_ff;
   reg [7:0] wr_hi_ff;
   reg [15:0] push_word_ff;
   reg [31:0] push_addr_ff;
   reg push_space_ff;
   reg push_ff;
   wire rise;
   wire fall;
   wire selected;
   wire [47:0] ca_full;
   wire [4:0] lat_now;
   wire emit_gap;
   wire fifo_in_ready;

   // ----------------------------------------------------------------
   // Synchronisers for all pins
   // ----------------------------------------------------------------
   // Two flops each, a third on the clock; no first flop feeds logic
   always @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         ck_m_ff <= 1'b0;
         ck_s_ff <= 1'b0;
         ck_d_ff <= 1'b0;
         cs_m_ff <= 1'b1;
         cs_s_ff <= 1'b1;
         dq_m_ff <= 8'h00;
         dq_s_ff <= 8'h00;
      end else begin
         ck_m_ff <= i_bus_clock;
         ck_s_ff <= ck_m_ff;
         ck_d_ff <= ck_s_ff;
         cs_m_ff <= i_cs_n;
         cs_s_ff <= cs_m_ff;
         dq_m_ff <= i_dq;
         dq_s_ff <= dq_m_ff;
      end
   end

   // Only the true clock is sampled; the complement is never needed
   assign rise = ck_s_ff & ~ck_d_ff;
   assign fall = ~ck_s_ff & ck_d_ff;
   assign selected = ~cs_s_ff;
   assign ca_full = {ca_ff[39:0], dq_s_ff};
   assign lat_now = lat_clocks(i_latency_count);
   assign emit_gap = page_end_ff & (gap_ff != 5'h00);

   // ----------------------------------------------------------------
   // Transaction engine
   // ----------------------------------------------------------------
   // Deselect wins over every edge, so a transfer ends mid-word
   always @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         state_ff <= ST_IDLE;
         ca_cnt_ff <= 3'h0;
         ca_ff <= 48'h0;
         lat_cnt_ff <= 5'h00;
         gap_ff <= 5'h00;
         page_end_ff <= 1'b0;
         cross_at_ff <= 4'h0;
         byte_b_ff <= 8'h00;
         word_ok_ff <= 1'b0;
         wr_hi_ff <= 8'h00;
         o_rd_addr <= 32'h0;
         o_dq <= 8'h00;
         o_dq_oe <= 1'b0;
         o_read_write_strobe <= 1'b0;
         o_read_write_strobe_oe <= 1'b0;
      end else if (!selected) begin
         state_ff <= ST_IDLE;
         ca_cnt_ff <= 3'h0;
         o_dq_oe <= 1'b0;
         o_read_write_strobe <= 1'b0;
         o_read_write_strobe_oe <= 1'b0;
      end else begin
         // Strobe low and driven from selection onward
         o_read_write_strobe_oe <= 1'b1;
         case (state_ff)
            // First edge after select is expected rising from low
            ST_IDLE: begin
               state_ff <= ST_CA;
               o_read_write_strobe <= 1'b0;
            end
            // Six bytes over three clocks, both edges
            ST_CA: begin
               if (rise | fall) begin
                  ca_ff <= ca_full;
                  ca_cnt_ff <= ca_cnt_ff + 3'h1;
                  if (ca_cnt_ff == `DFP_CA_BYTES - 3'h1) begin
                     o_rd_addr <= {ca_full[`DFP_CA_UPPER_MSB:
                                           `DFP_CA_UPPER_LSB],
                                   ca_full[`DFP_CA_LOWER_MSB:0]};
                     page_end_ff <= 1'b0;
                     // First crossing ends 16 words past the sub-page start
                     cross_at_ff <= {~ca_full[`DFP_CA_UPPER_LSB],
                                     `DFP_SUBPAGE_MASK};
                     lat_cnt_ff <= lat_now - 5'h01;
                     if (ca_full[`DFP_CA_RW_BIT]) begin
                        state_ff <= ST_LAT;
                        // Only linear reads pay at the crossing
                        if (ca_full[`DFP_CA_BURST_BIT]) begin
                           gap_ff <= gap_calc(
                              ca_full[`DFP_CA_LOWER_MSB:0], lat_now);
                        end else begin
                           gap_ff <= 5'h00;
                        end
                     end else begin
                        // Write framing ignores the burst-type bit
                        state_ff <= ST_WR;
                     end
                  end
               end
            end
            // Turnaround: device takes the data lines
            ST_LAT: begin
               o_dq_oe <= 1'b1;
               if (rise) begin
                  if (lat_cnt_ff == 5'h00) begin
                     state_ff <= ST_RD;
                     o_dq <= i_rd_data[15:8];
                     byte_b_ff <= i_rd_data[7:0];
                     word_ok_ff <= 1'b1;
                     o_read_write_strobe <= 1'b1;
                     o_rd_addr <= o_rd_addr + 32'h1;
                     if (o_rd_addr[3:0] == cross_at_ff) begin
                        page_end_ff <= 1'b1;
                     end
                  end else begin
                     lat_cnt_ff <= lat_cnt_ff - 5'h01;
                  end
               end
            end
            // One word per bus clock; invalid clocks hold strobe low
            ST_RD: begin
               if (rise) begin
                  if (emit_gap) begin
                     gap_ff <= gap_ff - 5'h01;
                     word_ok_ff <= 1'b0;
                     o_dq <= 8'h00;
                     o_read_write_strobe <= 1'b0;
                  end else begin
                     // Gap counter stays at zero afterwards
                     o_dq <= i_rd_data[15:8];
                     byte_b_ff <= i_rd_data[7:0];
                     word_ok_ff <= 1'b1;
                     o_read_write_strobe <= 1'b1;
                     o_rd_addr <= o_rd_addr + 32'h1;
                     if (o_rd_addr[3:0] == cross_at_ff) begin
                        page_end_ff <= 1'b1;
                     end
                  end
               end else if (fall) begin
                  o_dq <= word_ok_ff ? byte_b_ff : 8'h00;
                  o_read_write_strobe <= 1'b0;
               end
            end
            // Write data starts on the very next rising edge
            ST_WR: begin
               o_read_write_strobe <= 1'b0;
               if (rise) begin
                  wr_hi_ff <= dq_s_ff;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Write word assembly
   // ----------------------------------------------------------------
   // Bursts are accepted; the programming context is the host's duty
   always @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         push_ff <= 1'b0;
         push_word_ff <= 16'h0000;
         push_addr_ff <= 32'h0;
         push_space_ff <= 1'b0;
      end else begin
         push_ff <= 1'b0;
         if (selected && state_ff == ST_CA && (rise | fall) &&
             ca_cnt_ff == `DFP_CA_BYTES - 3'h1) begin
            push_addr_ff <= {ca_full[`DFP_CA_UPPER_MSB:
                                     `DFP_CA_UPPER_LSB],
                             ca_full[`DFP_CA_LOWER_MSB:0]};
            push_space_ff <= ca_full[`DFP_CA_SPACE_BIT];
         end else if (selected && state_ff == ST_WR && fall) begin
            push_ff <= 1'b1;
            push_word_ff <= {wr_hi_ff, dq_s_ff};
         end
         if (push_ff) begin
            push_addr_ff <= push_addr_ff + 32'h1;
         end
      end
   end

   // Bus cannot be stalled; a word refused by a full FIFO is flagged
   always @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_wr_overrun <= 1'b0;
      end else if (push_ff && !fifo_in_ready) begin
         o_wr_overrun <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Write FIFO toward the user side
   // ----------------------------------------------------------------
   dfp_fifo #(
      .WIDTH(`DFP_FIFO_WIDTH),
      .DEPTH(`DFP_FIFO_DEPTH),
      .AW(`DFP_FIFO_AW)
   ) u_wr_fifo (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .i_in_valid(push_ff),
      .o_in_ready(fifo_in_ready),
      .i_in_data({push_space_ff, push_addr_ff, push_word_ff}),
      .o_out_valid(o_wr_valid),
      .i_out_ready(i_wr_ready),
      .o_out_data({o_wr_space, o_wr_addr, o_wr_data})
   );

endmodule

// >>> dfp_port_assertions.sv
// Purpose: Port-level checks of the DDR flash bus port.
// Assumes: Pin edges show at the outputs 3 sys cycles later.
// Notes:   Bound to dfp_flash_port; one clock domain.
module dfp_port_assertions (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_bus_clock,
   input wire logic i_cs_n,
   input wire logic [7:0] o_dq,
   input wire logic o_dq_oe,
   input wire logic o_read_write_strobe,
   input wire logic o_read_write_strobe_oe,
   input wire logic o_wr_valid,
   input wire logic i_wr_ready,
   input wire logic [31:0] o_wr_addr,
   input wire logic [15:0] o_wr_data,
   input wire logic o_wr_overrun
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------
   // Checks, all on the system clock
   // ----------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);

   a_select_enables: assert property (
      !i_cs_n [*4] |-> o_read_write_strobe_oe)
      else $error("strobe enable missing while selected");
   a_deselect_ends: assert property (
      i_cs_n [*4] |-> !o_read_write_strobe_oe && !o_dq_oe)
      else $error("pins still driven after deselect");
   a_strobe_in_read: assert property (
      o_read_write_strobe |-> o_read_write_strobe_oe && o_dq_oe)
      else $error("strobe high outside a read");
   a_write_strobe_low: assert property (
      o_read_write_strobe_oe && !o_dq_oe |-> !o_read_write_strobe)
      else $error("strobe not low during write");
   // While dq is driven, strobe moves only three cycles after the matching pin edge
   a_strobe_rise_edge: assert property (
      $rose(o_read_write_strobe) |->
         $past(i_bus_clock, 3) && !$past(i_bus_clock, 4))
      else $error("strobe rose without a rising bus edge");
   a_strobe_fall_edge: assert property (
      $fell(o_read_write_strobe) && o_dq_oe |->
         !$past(i_bus_clock, 3) && $past(i_bus_clock, 4))
      else $error("strobe fell without a falling bus edge");
   a_dq_on_edge: assert property (
      o_dq_oe && $past(o_dq_oe) && $changed(o_dq) |->
         $past(i_bus_clock, 3) != $past(i_bus_clock, 4))
      else $error("read data moved between bus edges");
   a_fifo_hold: assert property (
      o_wr_valid && !i_wr_ready |=>
         o_wr_valid && $stable(o_wr_data) && $stable(o_wr_addr))
      else $error("write head changed while stalled");
   a_overrun_sticky: assert property (
      o_wr_overrun |=> o_wr_overrun)
      else $error("overrun flag cleared without reset");
endmodule

bind dfp_flash_port dfp_port_assertions u_port_assertions (
   .i_clk_sys, .i_reset_n, .i_bus_clock, .i_cs_n, .o_dq, .o_dq_oe,
   .o_read_write_strobe, .o_read_write_strobe_oe, .o_wr_valid,
   .i_wr_ready, .o_wr_addr, .o_wr_data, .o_wr_overrun
);

// >>> dfp_host_model.sv
// Purpose: Host memory controller model driving the bus pins.
// Assumes: Half bus period of 4 sys cycles (64 ns period).
// Notes:   Clock stands low between frames; released dq inverts.
module dfp_host_model (
   input wire logic i_clk_sys,
   input wire logic [7:0] i_dev_dq,
   input wire logic i_dev_strobe,
   output logic o_bus_clock,
   output logic o_cs_n,
   output logic [7:0] o_dq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------
   // Pin sequencing
   // ----------------------------------------------------------
   initial begin
      o_bus_clock = 1'b0;
      o_cs_n = 1'b1;
      o_dq = 8'h00;
   end

   // Single-ended clock only; data moves mid-half
   task automatic half(input logic lvl, input logic [7:0] nb,
         output logic [7:0] q, output logic s);
      o_bus_clock <= lvl;
      repeat (2) @(posedge i_clk_sys);
      o_dq <= nb;
      repeat (2) @(posedge i_clk_sys);
      q = i_dev_dq;
      s = i_dev_strobe;
   endtask

   // Select with clock low, then three command clocks
   task automatic frame_ca(input logic [47:0] ca, input logic [7:0] nb);
      logic [7:0] q;
      logic s;
      o_cs_n <= 1'b0;
      o_dq <= ca[47:40];
      repeat (4) @(posedge i_clk_sys);
      for (int i = 4; i >= 0; i--) begin
         half(~o_bus_clock, ca[8*i +: 8], q, s);
      end
      half(1'b0, nb, q, s);
   endtask

   // Deselect only while the clock is low
   task automatic close_frame();
      o_cs_n <= 1'b1;
      o_dq <= ~o_dq;
      repeat (6) @(posedge i_clk_sys);
   endtask
endmodule

// >>> ddr_flash_bus_read_write_port_test.sv
// Purpose: Self-checking bench of the DDR flash bus port.
// Assumes: Host model owns the bus pins; bench owns the rest.
// Notes:   Read array word is a fixed pattern of its address.
module ddr_flash_bus_read_write_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] latency_count = 4'h0;
   logic wr_ready = 1'b0;
   logic bus_clock, cs_n, dq_oe, strobe, strobe_oe;
   logic wr_valid, wr_space, wr_overrun;
   logic [7:0] dq_in, dq_out;
   logic [31:0] rd_addr, wr_addr;
   logic [15:0] rd_data, wr_data;
   int failures = 0;
   int n_checks = 0;

   // ----------------------------------------------------------
   // Clock, array and instances
   // ----------------------------------------------------------
   always #4 clk_sys = ~clk_sys;

   function automatic logic [15:0] word_of(input logic [31:0] a);
      return {a[7:0], a[7:0] ^ 8'ha5};
   endfunction

   assign rd_data = word_of(rd_addr);

   dfp_flash_port uut (
      .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_bus_clock(bus_clock),
      .i_cs_n(cs_n), .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe(dq_oe),
      .o_read_write_strobe(strobe), .o_read_write_strobe_oe(strobe_oe),
      .i_latency_count(latency_count), .o_rd_addr(rd_addr),
      .i_rd_data(rd_data), .o_wr_valid(wr_valid), .i_wr_ready(wr_ready),
      .o_wr_space(wr_space), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
      .o_wr_overrun(wr_overrun)
   );

   dfp_host_model host (
      .i_clk_sys(clk_sys), .i_dev_dq(dq_out), .i_dev_strobe(strobe),
      .o_bus_clock(bus_clock), .o_cs_n(cs_n), .o_dq(dq_in)
   );

   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------
   function automatic logic [47:0] mk_ca(input logic rw, sp, burst,
         input logic [31:0] a);
      return {rw, sp, burst, a[31:3], 13'h0000, a[2:0]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d, failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Drain with the far side stalling every other cycle
   task automatic drain(input int n, input logic [31:0] a, input logic sp);
      int got;
      got = 0;
      for (int c = 0; c < 400 && got < n; c++) begin
         @(posedge clk_sys);
         if (wr_valid === 1'b1 && wr_ready) begin
            check("write word", wr_data, {8'h40, got[7:0]});
            check("write address", wr_addr, a + got);
            check("write space", wr_space, sp);
            got++;
         end
         wr_ready <= c[0];
      end
      wr_ready <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check("fifo empty", wr_valid, 1'b0);
      if (got < n) begin
         check("words drained", got, n);
         complete_run();
      end
   endtask

   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   // One word, either burst-type value
   task automatic run_write_single(input logic burst);
      logic [7:0] q;
      logic s;
      host.frame_ca(mk_ca(1'b0, burst, burst, 32'h0000_0700), 8'h40);
      host.half(1'b1, 8'h00, q, s);
      check("write strobe", s, 1'b0);
      check("write strobe enable", strobe_oe, 1'b1);
      host.half(1'b0, 8'h40, q, s);
      check("write dq enable", dq_oe, 1'b0);
      host.close_frame();
      drain(1, 32'h0000_0700, burst);
   endtask

   // Burst of 33 words into a stalled 32-word buffer
   task automatic run_write_burst();
      logic [7:0] q;
      logic s;
      host.frame_ca(mk_ca(1'b0, 1'b1, 1'b1, 32'h0004_5678), 8'h40);
      for (int i = 0; i < 33; i++) begin
         host.half(1'b1, i[7:0], q, s);
         check("burst strobe", s, 1'b0);
         host.half(1'b0, 8'h40, q, s);
      end
      host.close_frame();
      check("overrun", wr_overrun, 1'b1);
      drain(32, 32'h0004_5678, 1'b1);
   endtask

   // Read with latency, first-word timing and page-crossing gap
   task automatic run_read(input logic burst, input logic [31:0] a,
         input logic [3:0] code);
      logic [7:0] qa, qb;
      logic sa, sb;
      int lat, gap, first, words, miss;
      lat = (code > 4'hb) ? 16 : int'(code) + 5;
      gap = int'(a[2:0]) + lat - 16;
      if (!burst || gap < 0)
         gap = 0;
      words = 0;
      first = 0;
      miss = 0;
      latency_count <= code;
      host.frame_ca(mk_ca(1'b1, 1'b0, burst, a), 8'h5a);
      for (int k = 3; k < 80 && words < 18; k++) begin
         host.half(1'b1, k[7:0], qa, sa);
         host.half(1'b0, ~k[7:0], qb, sb);
         check("read low strobe", sb, 1'b0);
         if (sa === 1'b1) begin
            if (words == 0)
               first = k;
            check("read byte A", qa, word_of(a + words) >> 8);
            check("read byte B", qb, word_of(a + words) & 16'h00ff);
            words++;
         end else if (words > 0) begin
            miss++;
            check("gap position", words, 16 - int'(a[2:0]));
         end
      end
      check("read dq enable", dq_oe, 1'b1);
      check("first word clock", first, lat + 2);
      check("gap clocks", miss, gap);
      host.close_frame();
      check("released strobe", strobe_oe, 1'b0);
      if (words < 18) begin
         check("read words", words, 18);
         complete_run();
      end
   endtask

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      run_write_single(1'b0);
      run_write_single(1'b1);
      run_write_burst();
      run_read(1'b1, 32'h0001_2341, 4'hb);
      run_read(1'b1, 32'h0001_2348, 4'hb);
      run_read(1'b1, 32'h0001_2347, 4'hb);
      run_read(1'b1, 32'h0001_2349, 4'hb);
      run_read(1'b0, 32'h0001_2347, 4'hb);
      run_read(1'b1, 32'h0001_2346, 4'h6);
      run_read(1'b1, 32'h0001_2343, 4'h0);
      run_read(1'b1, 32'h0001_2345, 4'hf);
      complete_run();
   end
endmodule
